//--- src/vccc_map.svh
// Register offsets, field positions, reset values for the sync/coast/clamp block
`ifndef VCCC_MAP_SVH
`define VCCC_MAP_SVH
`define VCCC_IDX_VSYNC_CTRL   8'h14
`define VCCC_IDX_VSYNC_DUR    8'h15
`define VCCC_IDX_PRE_COAST    8'h16
`define VCCC_IDX_POST_COAST   8'h17
`define VCCC_IDX_COAST_CLAMP  8'h18
`define VCCC_IDX_CLAMP_START  8'h19
`define VCCC_IDX_CLAMP_LEN    8'h1a
`define VCCC_IDX_CLAMP_POL    8'h1b
`define VCCC_IDX_STATUS       8'h1c
`define VCCC_VS_OVR_BIT       7
`define VCCC_VS_SRC_BIT       6
`define VCCC_VS_POLOVR_BIT    5
`define VCCC_VS_POL_BIT       4
`define VCCC_VS_OPOL_BIT      3
`define VCCC_VS_FILT_BIT      2
`define VCCC_VS_DUREN_BIT     1
`define VCCC_CO_SRC_BIT       7
`define VCCC_CO_POLOVR_BIT    6
`define VCCC_CO_POL_BIT       5
`define VCCC_CL_SRC_BIT       4
`define VCCC_CL_RED_BIT       3
`define VCCC_CL_GRN_BIT       2
`define VCCC_CL_BLU_BIT       1
`define VCCC_CL_POLOVR_BIT    7
`define VCCC_CL_POL_BIT       6
`define VCCC_RST_VSYNC_CTRL   8'h18
`define VCCC_RST_VSYNC_DUR    8'h0a
`define VCCC_RST_PRE_COAST    8'h00
`define VCCC_RST_POST_COAST   8'h00
`define VCCC_RST_COAST_CLAMP  8'h20
`define VCCC_RST_CLAMP_START  8'h08
`define VCCC_RST_CLAMP_LEN    8'h14
`define VCCC_RST_CLAMP_POL    8'h40
`endif

//--- src/vccc_pkg.sv
// Types shared by the sync/coast/clamp block
package vccc_pkg;
   typedef enum logic [1:0] {VCCC_CL_IDLE, VCCC_CL_WAIT, VCCC_CL_ON} vccc_clamp_st_t;
   typedef enum logic [1:0] {VCCC_CO_IDLE, VCCC_CO_VS, VCCC_CO_POST} vccc_coast_st_t;
endpackage : vccc_pkg

//--- src/vccc_top.sv
// Vsync processing, coast window and clamp window with an AHB-Lite register slave
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "vccc_map.svh"

// Summary of operation
// - Vsync override 0 lets hardware pick the vertical source (activity based).
// - With override, source bit 0 takes the pin, 1 the sync separator.
// - Polarity override 0 detects vertical pin polarity automatically; the separator is never inverted.
// - With override, polarity bit 0 means pin active low, 1 active high; reset 1.
// - Vertical output polarity bit 0 drives active low, 1 active high.
// - Vertical filter aligns the vertical sync onto horizontal sync edges.
// - Duration enable 0 passes width unchanged, 1 uses the duration register.
// - Eight-bit duration, in lines, used only when enabled; resets to ten.
// - Coast starts the programmed count of lines before vertical sync.
// - Coast extends the programmed count of lines after vertical sync.
// - Coast source 0 uses internal coast, 1 the external coast pin.
// - Coast polarity override 0 lets hardware determine coast polarity.
// - With coast override, bit 0 means active low, 1 active high.
// - Clamp source 0 selects internal timing, 1 the external clamp pin.
// - All three channels clamp together while the chosen clamp is active.
// - Clamp polarity auto when override 0, else bit selects low or high.
// - Per-channel bits choose ground (0) or midscale (1) clamp level.
// - Internal clamp begins placement pixels after the hsync trailing edge.
// - Internal clamp stays active for the programmed pixel count.
// - External clamp source makes placement and duration irrelevant.
module vccc_top
   import vccc_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        vsync_pin,
   input  wire logic        vsync_sep,
   input  wire logic        hsync_in,
   input  wire logic        coast_pin,
   input  wire logic        clamp_pin,
   output logic             vsync_out,
   output logic             pll_hold,
   output logic             clamp_active,
   output logic             clamp_mid_red,
   output logic             clamp_mid_green,
   output logic             clamp_mid_blue
);

   // ---------------------------------------------------------------
   // Registers and bus slave
   // ---------------------------------------------------------------
   logic [7:0]  vs_ctrl_r, vs_dur_r, pre_r, post_r, cc_ctrl_r, cl_start_r, cl_len_r, cl_pol_r;
   logic        wr_pend_r;
   logic [5:0]  wr_idx_r;
   logic [31:0] hrdata_r;
   logic [7:0]  status_w;

   // Address phase qualifiers
   wire         acc_w   = hsel && hready && htrans[1];
   wire [5:0]   idx_w   = haddr[7:2];
   logic [31:0] rd_w;

   function automatic logic [7:0] rd_mux(input logic [5:0] i);
      case ({2'b00, i})
         `VCCC_IDX_VSYNC_CTRL:  rd_mux = vs_ctrl_r;
         `VCCC_IDX_VSYNC_DUR:   rd_mux = vs_dur_r;
         `VCCC_IDX_PRE_COAST:   rd_mux = pre_r;
         `VCCC_IDX_POST_COAST:  rd_mux = post_r;
         `VCCC_IDX_COAST_CLAMP: rd_mux = {cc_ctrl_r[7:1], 1'b0};
         `VCCC_IDX_CLAMP_START: rd_mux = cl_start_r;
         `VCCC_IDX_CLAMP_LEN:   rd_mux = cl_len_r;
         `VCCC_IDX_CLAMP_POL:   rd_mux = {cl_pol_r[7:6], 6'h00};
         `VCCC_IDX_STATUS:      rd_mux = status_w;
         default:               rd_mux = 8'h00;   // Unmapped reads zero
      endcase
   endfunction : rd_mux

   // Read mux as a process: an assign would only wake on the index and
   // return a stale byte when a write is read back at the same address
   always_comb rd_w = {24'h0000_00, rd_mux(idx_w)};

   // Address phase capture; zero-wait answer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_idx_r  <= 6'h00;
         hrdata_r  <= 32'h0000_0000;
      end else begin
         wr_pend_r <= acc_w && hwrite;
         wr_idx_r  <= idx_w;
         hrdata_r  <= (acc_w && !hwrite) ? rd_w : hrdata_r;
      end
   end

   // Data phase write into the addressed register
   wire [7:0] wd_w = hwdata[7:0];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vs_ctrl_r  <= `VCCC_RST_VSYNC_CTRL;
         vs_dur_r   <= `VCCC_RST_VSYNC_DUR;
         pre_r      <= `VCCC_RST_PRE_COAST;
         post_r     <= `VCCC_RST_POST_COAST;
         cc_ctrl_r  <= `VCCC_RST_COAST_CLAMP;
         cl_start_r <= `VCCC_RST_CLAMP_START;
         cl_len_r   <= `VCCC_RST_CLAMP_LEN;
         cl_pol_r   <= `VCCC_RST_CLAMP_POL;
      end else if (wr_pend_r) begin
         case ({2'b00, wr_idx_r})
            `VCCC_IDX_VSYNC_CTRL:  vs_ctrl_r  <= wd_w;
            `VCCC_IDX_VSYNC_DUR:   vs_dur_r   <= wd_w;
            `VCCC_IDX_PRE_COAST:   pre_r      <= wd_w;
            `VCCC_IDX_POST_COAST:  post_r     <= wd_w;
            `VCCC_IDX_COAST_CLAMP: cc_ctrl_r  <= wd_w;
            `VCCC_IDX_CLAMP_START: cl_start_r <= wd_w;
            `VCCC_IDX_CLAMP_LEN:   cl_len_r   <= wd_w;
            `VCCC_IDX_CLAMP_POL:   cl_pol_r   <= wd_w;
            default: ;
         endcase
      end
   end

   assign hrdata    = hrdata_r;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [4:0] s1_r, s2_r, s3_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_r <= 5'h00;
         s2_r <= 5'h00;
         s3_r <= 5'h00;
      end else begin
         s1_r <= {clamp_pin, coast_pin, hsync_in, vsync_sep, vsync_pin};
         s2_r <= s1_r;
         s3_r <= s2_r;   // Delayed copy for edges and polarity sampling
      end
   end
   wire vpin_w = s2_r[0];
   wire vsep_w = s2_r[1];
   wire hs_w   = s2_r[2];

   // ---------------------------------------------------------------
   // Polarity detectors: the idle level is the one seen most often
   // ---------------------------------------------------------------
   // Whole phases are compared: the longer of the last high and the last
   // low phase is the idle level. A small up/down counter would saturate
   // inside a vertical pulse of several lines and flip the polarity there.
   // Limitation: the choice settles only after one full period of the pin.
   // A pin with no edge for 65535 clocks takes its steady level as idle.
   logic [15:0] run_cnt_r [0:3];
   logic [15:0] hi_len_r  [0:3];
   logic [15:0] lo_len_r  [0:3];
   logic [3:0]  auto_low_r;
   wire  [3:0]  lvl_w   = {s2_r[4], s2_r[3], s2_r[2], s2_r[0]};
   wire  [3:0]  lvl_q_w = {s3_r[4], s3_r[3], s3_r[2], s3_r[0]};
   for (genvar g = 0; g < 4; g++) begin : g_pol
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            run_cnt_r[g]  <= 16'h0000;
            hi_len_r[g]   <= 16'h0000;
            lo_len_r[g]   <= 16'h0000;
            auto_low_r[g] <= 1'b0;
         end else begin
            if (lvl_w[g] != lvl_q_w[g]) begin
               run_cnt_r[g] <= 16'h0001;   // Phase just ended: keep its length
               if (lvl_q_w[g]) hi_len_r[g] <= run_cnt_r[g];
               else lo_len_r[g] <= run_cnt_r[g];
            end else if (run_cnt_r[g] != 16'hffff) begin
               run_cnt_r[g] <= run_cnt_r[g] + 16'h0001;
            end
            // Idle high means active low
            auto_low_r[g] <= (run_cnt_r[g] == 16'hffff) ? lvl_w[g]
                                                       : (hi_len_r[g] > lo_len_r[g]);
         end
      end
   end

   // Active-high normalisation
   wire hs_act_w = hs_w ^ auto_low_r[1];
   wire hs_prv_w = s3_r[2] ^ auto_low_r[1];
   wire hs_lead_w  = hs_act_w && !hs_prv_w;
   wire hs_trail_w = !hs_act_w && hs_prv_w;

   // ---------------------------------------------------------------
   // Vertical source, polarity and filter
   // ---------------------------------------------------------------
   // Auto source: prefer the pin when it has toggled recently
   logic [15:0] pin_act_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) pin_act_r <= 16'h0000;
      else if (s2_r[0] != s3_r[0]) pin_act_r <= 16'hffff;
      else if (pin_act_r != 16'h0000) pin_act_r <= pin_act_r - 16'h0001;
   end
   wire pin_alive_w = pin_act_r != 16'h0000;
   wire use_sep_w = vs_ctrl_r[`VCCC_VS_OVR_BIT] ? vs_ctrl_r[`VCCC_VS_SRC_BIT]
                                                : !pin_alive_w;
   wire v_raw_w   = use_sep_w ? vsep_w : vpin_w;
   wire v_low_w   = vs_ctrl_r[`VCCC_VS_POLOVR_BIT] ? !vs_ctrl_r[`VCCC_VS_POL_BIT]
                                                   : auto_low_r[0];
   wire v_act_w   = use_sep_w ? vsep_w : (v_raw_w ^ v_low_w);

   // Filtered vsync changes only on hsync leading edges
   logic v_filt_r, v_prev_r;
   wire  v_sel_w  = vs_ctrl_r[`VCCC_VS_FILT_BIT] ? v_filt_r : v_act_w;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         v_filt_r <= 1'b0;
         v_prev_r <= 1'b0;
      end else begin
         if (hs_lead_w) v_filt_r <= v_act_w;
         v_prev_r <= v_sel_w;
      end
   end
   wire v_rise_w = v_sel_w && !v_prev_r;
   wire v_fall_w = !v_sel_w && v_prev_r;

   // Duration shaping in lines
   logic [7:0] vdur_cnt_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) vdur_cnt_r <= 8'h00;
      else if (v_rise_w) vdur_cnt_r <= vs_dur_r;
      else if (hs_lead_w && vdur_cnt_r != 8'h00) vdur_cnt_r <= vdur_cnt_r - 8'h01;
   end
   wire v_shaped_w = vs_ctrl_r[`VCCC_VS_DUREN_BIT] ? (vdur_cnt_r != 8'h00) : v_sel_w;

   logic vsync_out_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) vsync_out_r <= 1'b0;
      else vsync_out_r <= v_shaped_w ^ !vs_ctrl_r[`VCCC_VS_OPOL_BIT];
   end
   assign vsync_out = vsync_out_r;

   // ---------------------------------------------------------------
   // Coast window
   // ---------------------------------------------------------------
   // Pre-coast needs a line count learnt from the previous frame
   logic [15:0] line_cnt_r, frame_lines_r, post_cnt_r;
   vccc_coast_st_t co_st_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_cnt_r    <= 16'h0000;
         frame_lines_r <= 16'hffff;
      end else if (v_rise_w) begin
         line_cnt_r    <= 16'h0000;
         frame_lines_r <= line_cnt_r;
      end else if (hs_lead_w) begin
         line_cnt_r <= line_cnt_r + 16'h0001;
      end
   end
   wire pre_win_w = (pre_r != 8'h00) &&
                    (line_cnt_r + {8'h00, pre_r} >= frame_lines_r);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         co_st_r    <= VCCC_CO_IDLE;
         post_cnt_r <= 16'h0000;
      end else begin
         unique case (co_st_r)
            VCCC_CO_IDLE: if (v_rise_w) co_st_r <= VCCC_CO_VS;
            VCCC_CO_VS: if (v_fall_w) begin
               co_st_r    <= VCCC_CO_POST;
               post_cnt_r <= {8'h00, post_r};
            end
            VCCC_CO_POST: begin
               if (post_cnt_r == 16'h0000) co_st_r <= VCCC_CO_IDLE;
               else if (hs_lead_w) post_cnt_r <= post_cnt_r - 16'h0001;
            end
         endcase
      end
   end
   wire co_int_w  = pre_win_w || (co_st_r != VCCC_CO_IDLE);
   wire co_low_w  = cc_ctrl_r[`VCCC_CO_POLOVR_BIT] ? !cc_ctrl_r[`VCCC_CO_POL_BIT]
                                                   : auto_low_r[2];
   wire co_ext_w  = s2_r[3] ^ co_low_w;
   wire coast_w   = cc_ctrl_r[`VCCC_CO_SRC_BIT] ? co_ext_w : co_int_w;

   logic pll_hold_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) pll_hold_r <= 1'b0;
      else pll_hold_r <= coast_w;
   end
   assign pll_hold = pll_hold_r;

   // ---------------------------------------------------------------
   // Clamp window
   // ---------------------------------------------------------------
   vccc_clamp_st_t cl_st_r;
   logic [7:0]     cl_cnt_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cl_st_r  <= VCCC_CL_IDLE;
         cl_cnt_r <= 8'h00;
      end else if (hs_trail_w) begin
         cl_st_r  <= VCCC_CL_WAIT;
         cl_cnt_r <= cl_start_r;
      end else begin
         unique case (cl_st_r)
            VCCC_CL_IDLE: ;
            VCCC_CL_WAIT: begin
               if (cl_cnt_r <= 8'h01) begin
                  cl_st_r  <= VCCC_CL_ON;
                  cl_cnt_r <= cl_len_r;
               end else cl_cnt_r <= cl_cnt_r - 8'h01;
            end
            VCCC_CL_ON: begin
               if (cl_cnt_r <= 8'h01) cl_st_r <= VCCC_CL_IDLE;
               else cl_cnt_r <= cl_cnt_r - 8'h01;
            end
         endcase
      end
   end
   wire cl_low_w = cl_pol_r[`VCCC_CL_POLOVR_BIT] ? !cl_pol_r[`VCCC_CL_POL_BIT]
                                                 : auto_low_r[3];
   wire cl_ext_w = s2_r[4] ^ cl_low_w;
   // External source bypasses the counters entirely
   wire clamp_w  = cc_ctrl_r[`VCCC_CL_SRC_BIT] ? cl_ext_w
                                              : (cl_st_r == VCCC_CL_ON);

   logic [3:0] cl_out_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) cl_out_r <= 4'h0;
      else cl_out_r <= {clamp_w, cc_ctrl_r[`VCCC_CL_RED_BIT],
                        cc_ctrl_r[`VCCC_CL_GRN_BIT], cc_ctrl_r[`VCCC_CL_BLU_BIT]};
   end
   assign clamp_active    = cl_out_r[3];
   assign clamp_mid_red   = cl_out_r[2];
   assign clamp_mid_green = cl_out_r[1];
   assign clamp_mid_blue  = cl_out_r[0];

   // Status: live state for software
   assign status_w = {3'b000, use_sep_w, pin_alive_w, clamp_w, coast_w, v_sel_w};
endmodule : vccc_top

//--- test/vccc_props.sv
// Checker for bus answers, clamp, coast and vsync outputs
`timescale 1ns/1ps
`include "vccc_map.svh"
module vccc_props (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        vsync_pin,
   input wire logic        hsync_in,
   input wire logic        coast_pin,
   input wire logic        clamp_pin,
   input wire logic        vsync_out,
   input wire logic        pll_hold,
   input wire logic        clamp_active,
   input wire logic        clamp_mid_red,
   input wire logic        clamp_mid_green,
   input wire logic        clamp_mid_blue
);
   logic       rd_ph, wr_ph, hs_q;
   logic [7:0] wa, c14, c18, c19, c1a, c1b;
   logic [8:0] age, since_h, run;
   wire        take = hsel & hready & htrans[1];
   // ---
   // Shadow registers
   // ---
   // Age saturates, so window checks skip lines cut short by a write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {rd_ph, wr_ph, wa, age, c14} <= {19'h0_0000, `VCCC_RST_VSYNC_CTRL};
         {c18, c1b} <= {`VCCC_RST_COAST_CLAMP, `VCCC_RST_CLAMP_POL};
         {c19, c1a} <= {`VCCC_RST_CLAMP_START, `VCCC_RST_CLAMP_LEN};
      end else begin
         rd_ph <= take & ~hwrite;
         wr_ph <= take & hwrite;
         wa    <= haddr[9:2];
         age   <= wr_ph ? 9'h000 : age + {8'h00, age != 9'h1ff};
         if (wr_ph && wa == `VCCC_IDX_VSYNC_CTRL) c14 <= hwdata[7:0];
         if (wr_ph && wa == `VCCC_IDX_COAST_CLAMP) c18 <= hwdata[7:0];
         if (wr_ph && wa == `VCCC_IDX_CLAMP_START) c19 <= hwdata[7:0];
         if (wr_ph && wa == `VCCC_IDX_CLAMP_LEN) c1a <= hwdata[7:0];
         if (wr_ph && wa == `VCCC_IDX_CLAMP_POL) c1b <= hwdata[7:0];
      end
   end
   // Pixels since hsync fell, and length of the running clamp window
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {hs_q, since_h, run} <= 19'h0_0000;
      end else begin
         hs_q    <= hsync_in;
         since_h <= (hs_q & ~hsync_in) ? 9'h000 : since_h + {8'h00, since_h != 9'h1ff};
         run     <= clamp_active ? run + 9'h001 : 9'h000;
      end
   end
   // ---
   // Properties
   // ---
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_resp_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
      else $error("bus answer not ready or not okay");
   a_rd_upper: assert property (rd_ph |-> hrdata[31:8] == 24'h00_0000)
      else $error("upper read data not zero");
   a_rd_unmapped: assert property (rd_ph && (wa < 8'h14 || wa > 8'h1c) |-> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_mid_level: assert property (age >= 9'h004 |-> {clamp_mid_red, clamp_mid_green, clamp_mid_blue} == c18[3:1])
      else $error("clamp level outputs differ from control");
   a_clamp_len: assert property ($fell(clamp_active) && !c18[4] && age == 9'h1ff |-> run == {1'b0, c1a})
      else $error("clamp window length wrong");
   a_clamp_place: assert property ($rose(clamp_active) && !c18[4] && age == 9'h1ff |->
      since_h >= {1'b0, c19} && since_h <= {1'b0, c19} + 9'h006)
      else $error("clamp window start wrong");
   a_clamp_ext: assert property (c18[4] && c1b[7:6] == 2'b11 && $rose(clamp_pin) |-> ##[1:6] clamp_active)
      else $error("external clamp not followed");
   a_coast_ext: assert property (c18[7:5] == 3'b111 && $rose(coast_pin) |-> ##[1:6] pll_hold)
      else $error("external coast not followed");
   a_vs_pol: assert property ((c14 & 8'hf6) == 8'hb0 && $rose(vsync_pin) |-> ##[1:6] vsync_out == c14[3])
      else $error("vsync output level wrong");
   c_clamp: cover property ($fell(clamp_active));
   c_coast: cover property ($rose(pll_hold));
   c_read: cover property (rd_ph);
endmodule : vccc_props

bind vccc_top vccc_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .hrdata, .hreadyout, .hresp, .vsync_pin, .hsync_in, .coast_pin, .clamp_pin,
   .vsync_out, .pll_hold, .clamp_active, .clamp_mid_red, .clamp_mid_green, .clamp_mid_blue);

//--- test/vccc_video_src.sv
// Video source model: free hsync, framed vsync on pin and separator
`timescale 1ns/1ps
module vccc_video_src #(
   parameter int HP    = 280,
   parameter int HW    = 8,
   parameter int LINES = 6,
   parameter int VW    = 2
) (
   input  wire logic clk,
   input  wire logic rst_n,
   output logic      hsync,
   output logic      vsync,
   output logic      vsync_sep
);
   int px = 0;
   int ln = 0;
   int pos;
   // Pixel and line counters of one frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         px <= 0;
         ln <= 0;
      end else begin
         px <= (px == HP - 1) ? 0 : px + 1;
         if (px == HP - 1) ln <= (ln == LINES - 1) ? 0 : ln + 1;
      end
   end
   // Vsync lags hsync so the filter has edges to align; separator runs one line longer
   assign pos       = ln * HP + px;
   assign hsync     = (px < HW);
   assign vsync     = (pos >= 40) && (pos < VW * HP + 40);
   assign vsync_sep = (pos >= 40) && (pos < (VW + 1) * HP + 40);
endmodule : vccc_video_src

//--- test/vccc_tb_top.sv
// Self-checking bench for the vsync, coast and clamp block
`timescale 1ns/1ps
`include "vccc_map.svh"
module vccc_tb_top;
   localparam int HP = 280;
   localparam int FR = 6 * HP;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'b010;
   logic        hreadyout, hresp, vsync_pin, vsync_sep, hsync_in, vsync_out, pll_hold;
   logic        coast_pin = 1'b0, clamp_pin = 1'b0, vact = 1'b1, clamp_active;
   logic        clamp_mid_red, clamp_mid_green, clamp_mid_blue;
   wire         hready = hreadyout;
   wire  [2:0]  obs = {clamp_active, pll_hold, vsync_out ~^ vact};
   int          fails = 0, total_checks = 0, w;
   // Rows: index, write flag, write data, expected readback
   logic [31:0] rg [18] = '{32'h1400_0018, 32'h1500_000a, 32'h1600_0000, 32'h1700_0000,
      32'h1800_0020, 32'h1900_0008, 32'h1a00_0014, 32'h1b00_0040, 32'h1d00_0000,
      32'h1d01_ff00, 32'h1501_a5a5, 32'h1901_0101, 32'h1a01_ffff, 32'h1601_5a5a,
      32'h1701_c3c3, 32'h1b01_ffc0, 32'h1401_ffff, 32'h1801_f1f0};
   // Rows: vsync control, pre, post, observed output, expected lines
   logic [31:0] vr [10] = '{32'hb800_0002, 32'hb000_0002, 32'hf800_0003, 32'ha800_0004,
      32'h3800_0002, 32'hbc00_0002, 32'hbe00_0004, 32'hb801_0215, 32'hb800_0012,
      32'h9800_0002};
   logic [15:0] cl [3] = '{16'h0814, 16'h01ff, 16'h0307};
   always #25 hclk = ~hclk;
   vccc_video_src #(.HP(HP), .HW(8), .LINES(6), .VW(2)) u_src (.clk(hclk), .rst_n(hresetn),
      .hsync(hsync_in), .vsync(vsync_pin), .vsync_sep(vsync_sep));
   vccc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hrdata, .hreadyout, .hresp, .vsync_pin, .vsync_sep, .hsync_in, .coast_pin, .clamp_pin,
      .vsync_out, .pll_hold, .clamp_active, .clamp_mid_red, .clamp_mid_green, .clamp_mid_blue);
   // ---
   // Tasks
   // ---
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_w(input int got, input int exp, input int tol);
      total_checks++;
      if (got < exp - tol || got > exp + tol) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_w
   // Slave may stretch; only the watchdog bounds the wait
   task automatic wait_rdy();
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask : wait_rdy
   task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] q);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= {22'h00_0000, idx, 2'b00};
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      q = hrdata;   // Select stays up between calls; each back-to-back call drives it high again
   endtask : ahb
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      ahb(1'b1, idx, {24'h00_0000, d}, rd);
   endtask : wr
   task automatic rst();
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      chk({24'h00_0000, vsync_out, pll_hold, clamp_active, clamp_mid_red, clamp_mid_green,
           clamp_mid_blue, hreadyout, hresp}, 32'h0000_0002);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask : rst
   // High time of one output, sampled on the falling edge away from updates
   task automatic width(input int s, output int n);
      int t;
      t = 0;
      n = 0;
      while (obs[s] !== 1'b0 && t < 3 * FR) begin @(negedge hclk); t++; end
      while (obs[s] !== 1'b1 && t < 6 * FR) begin @(negedge hclk); t++; end
      while (obs[s] === 1'b1 && n < FR) begin @(negedge hclk); n++; end
      @(posedge hclk);
   endtask : width
   // First window after a change may be cut short, so the second one counts
   task automatic meas(input int s, input int exp, input int tol);
      width(s, w);
      width(s, w);
      chk_w(w, exp, tol);
   endtask : meas
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   // ---
   // Sequence
   // ---
   initial begin
      rst();
      for (int i = 0; i < 18; i++) begin
         if (rg[i][16]) wr(rg[i][31:24], rg[i][15:8]);
         ahb(1'b0, rg[i][31:24], 32'h0000_0000, rd);
         chk(rd, {24'h00_0000, rg[i][7:0]});
      end
      rst();
      ahb(1'b0, `VCCC_IDX_VSYNC_DUR, 32'h0000_0000, rd);
      chk(rd, 32'h0000_000a);
      for (int i = 0; i < 3; i++) begin
         wr(`VCCC_IDX_CLAMP_START, cl[i][15:8]);
         wr(`VCCC_IDX_CLAMP_LEN, cl[i][7:0]);
         meas(2, cl[i][7:0], 0);
      end
      for (int i = 0; i < 2; i++) begin
         wr(`VCCC_IDX_COAST_CLAMP, i ? 8'h24 : 8'h2a);
         repeat (4) @(posedge hclk);
         chk({29'h0000_0000, clamp_mid_red, clamp_mid_green, clamp_mid_blue},
             i ? 32'h0000_0002 : 32'h0000_0005);
      end
      // External clamp then external coast, each with both input polarities
      for (int k = 0; k < 4; k++) begin
         if (k < 2) wr(`VCCC_IDX_CLAMP_POL, k[0] ? 8'hc0 : 8'h80);
         wr(`VCCC_IDX_COAST_CLAMP, (k < 2) ? 8'h30 : (k[0] ? 8'he0 : 8'hc0));
         if (k < 2) clamp_pin <= ~k[0]; else coast_pin <= ~k[0];
         repeat (20) @(posedge hclk);
         fork
            width((k < 2) ? 2 : 1, w);
            begin
               repeat (5) @(posedge hclk);
               if (k < 2) clamp_pin <= k[0]; else coast_pin <= k[0];
               repeat (12) @(posedge hclk);
               if (k < 2) clamp_pin <= ~k[0]; else coast_pin <= ~k[0];
            end
         join
         chk_w(w, 12, 0);
         w = 0;
         repeat (HP) begin @(negedge hclk); w += obs[(k < 2) ? 2 : 1]; end
         chk_w(w, 0, 0);
         @(posedge hclk);
      end
      rst();
      wr(`VCCC_IDX_VSYNC_DUR, 8'h04);
      for (int i = 0; i < 10; i++) begin
         wr(`VCCC_IDX_VSYNC_CTRL, vr[i][31:24]);
         wr(`VCCC_IDX_PRE_COAST, vr[i][23:16]);
         wr(`VCCC_IDX_POST_COAST, vr[i][15:8]);
         vact = vr[i][27];
         meas(vr[i][7:4], vr[i][3:0] * HP, HP / 2);
      end
      report_and_stop();
   end
   // Hang guard, well above the expected run length
   initial begin
      repeat (95000) @(posedge hclk);
      fails++;
      report_and_stop();
   end
endmodule : vccc_tb_top
